// >>> core/adc_pmc_regs.svh
// constants for the converter power and mode controller
// assumes inclusion by bare name from design files
`ifndef ADC_PMC_REGS_SVH
`define ADC_PMC_REGS_SVH
// register offsets (word index on the plain register port)
`define REG_CTRL        4'h0
`define REG_CHAN_PD     4'h1
`define REG_STATUS      4'h2
`define REG_RESULT      4'h3
// control register fields
`define CTRL_DCS_EN     0
`define CTRL_SW_STANDBY_REQUEST_PIN    1
`define CTRL_RATE_CHG   2
// reset values
`define CTRL_RESET      32'h0000_0001
`define CHAN_PD_RESET   8'h00
// timing
`define DLL_RELOCK_CYC  4'd8
`define STANDBY_REQUEST_PIN_WAKE_CYC   8'd20
`define PD_WAKE_MAX     16'h0100
`define PIPE_DEPTH      4'd10
`endif

// >>> core/adc_pmc_pkg.sv
// types for the converter power and mode controller
// assumes nothing beyond the regs header
package adc_pmc_pkg;
    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_STANDBY_REQUEST_PIN  = 2'b01,
        PM_FULL_POWERDOWN_PIN  = 2'b11,
        PM_WAKE  = 2'b10
    } pmode_e;
endpackage : adc_pmc_pkg

// >>> core/pipe_stage.sv
// one pipeline stage holding a partial code and its valid flag
// assumes a free running ref_clk shared with the top
`timescale 1ns/100ps
module pipe_stage #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // stage data
    input  wire logic [W-1:0] in_code,
    input  wire logic         in_vld,
    output logic      [W-1:0] out_code,
    output logic              out_vld
);
    // stage register, advances on every rising edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            out_code <= '0;
            out_vld  <= 1'b0;
        end else begin
            out_code <= in_code;
            out_vld  <= in_vld;
        end
    end
endmodule : pipe_stage

// >>> core/adc_power_mode_control.sv
// power, standby, stabiliser and pipeline control around the converter
// assumes mode pins are asynchronous; sample clock is ref_clk
// Operation
// - capture sample on rising clock edge
// - combine stage outputs into 12-bit result; here the 12-bit result is the last stage code unchanged
// - pipeline holds several samples in flight
// - serialize words aligned to frame clock
// - stabiliser gives nominal 50% internal clock; here duty_cycle_stabiliser_q is only an enable level and no clock is generated
// - stabiliser can be switched off
// - about eight cycles relock after rate change
// - power-down pin shuts reference, buffer, PLL, bias
// - outputs high impedance during power-down
// - resume after wake-up time when released
// - wake-up grows with time powered down
// - standby pin powers all but references
// - standby recovery takes 20 cycles; power-down recovery takes the cycles spent down, up to 256
// - channels powered down individually by software
// - software standby keeps PLL running
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "adc_pmc_regs.svh"
module adc_power_mode_control
    import adc_pmc_pkg::*;
#(
    parameter int CH    = 8,
    parameter int W     = 12,
    parameter int FIRST = 4
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // mode pins
    input  wire logic          full_powerdown_pin,
    input  wire logic          standby_request_pin,
    // quantizer inputs, sampled on ref_clk
    input  wire logic [W-1:0]  stage_code,
    // register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    // analog enables
    output logic               ref_en_q,
    output logic               refbuf_en_q,
    output logic               pll_en_q,
    output logic               bias_en_q,
    output logic      [CH-1:0] chan_en_q,
    // stabiliser
    output logic               duty_cycle_stabiliser_q,
    output logic               dll_locked_q,
    // serial outputs
    output logic      [CH-1:0] ser_data_q,
    output logic      [CH-1:0] ser_oe_q,
    output logic               frame_clk_q,
    output logic               frame_oe_q,
    output logic               data_valid_q
);
    initial begin
        if (W != 12 || CH < 1 || CH > 8 || FIRST < 1 || FIRST >= W)
            $error("adc_power_mode_control: unsupported parameters");
    end

    // pin synchronisers
    logic pd_s1_q, pd_s2_q, sb_s1_q, sb_s2_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            sb_s1_q <= 1'b0;
            sb_s2_q <= 1'b0;
        end else begin
            pd_s1_q <= full_powerdown_pin;
            pd_s2_q <= pd_s1_q;
            sb_s1_q <= standby_request_pin;
            sb_s2_q <= sb_s1_q;
        end
    end

    // software registers
    logic [31:0]   ctrl_q;
    logic [CH-1:0] chan_pd_q;
    wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
    wire wr_chpd = reg_wr && (reg_addr == `REG_CHAN_PD);
    wire rate_chg = wr_ctrl && reg_wdata[`CTRL_RATE_CHG];
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_q    <= `CTRL_RESET;
            chan_pd_q <= CH'(`CHAN_PD_RESET);
        end else begin
            if (wr_ctrl)
                ctrl_q <= {29'h0000_0000, 1'b0, reg_wdata[`CTRL_SW_STANDBY_REQUEST_PIN], reg_wdata[`CTRL_DCS_EN]};
            if (wr_chpd)
                chan_pd_q <= reg_wdata[CH-1:0];
        end
    end
    wire dcs_on   = ctrl_q[`CTRL_DCS_EN];
    wire sw_standby_request_pin  = ctrl_q[`CTRL_SW_STANDBY_REQUEST_PIN];

    // mode requests, power-down governs
    wire req_pd   = pd_s2_q;
    wire req_sb   = !pd_s2_q && (sb_s2_q || sw_standby_request_pin);

    // power state machine and wake counters
    pmode_e    mode_q, mode_d;
    logic [15:0] pd_time_q;
    logic [15:0] wake_q;
    wire wake_done = (wake_q == 16'h0000);
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PM_RUN:  if (req_pd) mode_d = PM_FULL_POWERDOWN_PIN;
                     else if (req_sb) mode_d = PM_STANDBY_REQUEST_PIN;
            PM_STANDBY_REQUEST_PIN: if (req_pd) mode_d = PM_FULL_POWERDOWN_PIN;
                     else if (!req_sb) mode_d = PM_WAKE;
            PM_FULL_POWERDOWN_PIN: if (!req_pd) mode_d = PM_WAKE;
            PM_WAKE: if (req_pd) mode_d = PM_FULL_POWERDOWN_PIN;
                     else if (req_sb) mode_d = PM_STANDBY_REQUEST_PIN;
                     else if (wake_done) mode_d = PM_RUN;
            default: mode_d = PM_FULL_POWERDOWN_PIN;
        endcase
    end
    wire pd_sat = (pd_time_q == `PD_WAKE_MAX);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mode_q    <= PM_RUN;
            pd_time_q <= 16'h0000;
            wake_q    <= 16'h0000;
        end else begin
            mode_q <= mode_d;
            if (mode_q == PM_FULL_POWERDOWN_PIN && !pd_sat)
                pd_time_q <= pd_time_q + 16'h0001;
            else if (mode_q == PM_RUN)
                pd_time_q <= 16'h0000;
            if (mode_q == PM_FULL_POWERDOWN_PIN && mode_d == PM_WAKE)
                wake_q <= (pd_time_q == 16'h0000) ? 16'h0001 : pd_time_q;
            else if (mode_q == PM_STANDBY_REQUEST_PIN && mode_d == PM_WAKE)
                wake_q <= {8'h00, `STANDBY_REQUEST_PIN_WAKE_CYC};
            else if (mode_q == PM_WAKE && !wake_done)
                wake_q <= wake_q - 16'h0001;
        end
    end

    // analog enables per mode
    wire run    = (mode_q == PM_RUN);
    wire in_pd  = (mode_q == PM_FULL_POWERDOWN_PIN);
    wire in_sb  = (mode_q == PM_STANDBY_REQUEST_PIN);
    wire sb_pin = sb_s2_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ref_en_q    <= 1'b1;
            refbuf_en_q <= 1'b1;
            pll_en_q    <= 1'b1;
            bias_en_q   <= 1'b1;
            chan_en_q   <= '1;
        end else begin
            ref_en_q    <= !in_pd;
            refbuf_en_q <= !in_pd && !in_sb;
            pll_en_q    <= !in_pd && !(in_sb && sb_pin);
            bias_en_q   <= !in_pd && !in_sb;
            chan_en_q   <= run ? ~chan_pd_q : '0;
        end
    end

    // stabiliser and relock counter
    logic [3:0] lock_cnt_q;
    logic       dcs_dly_q;
    wire relock = rate_chg || (dcs_on != dcs_dly_q) || !run;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lock_cnt_q              <= `DLL_RELOCK_CYC;
            dcs_dly_q               <= 1'b1;
            dll_locked_q            <= 1'b0;
            duty_cycle_stabiliser_q <= 1'b1;
        end else begin
            dcs_dly_q               <= dcs_on;
            duty_cycle_stabiliser_q <= dcs_on;
            if (relock)
                lock_cnt_q <= `DLL_RELOCK_CYC;
            else if (lock_cnt_q != 4'd0)
                lock_cnt_q <= lock_cnt_q - 4'd1;
            dll_locked_q <= !relock && (lock_cnt_q <= 4'd1);
        end
    end

    // capture and correction pipeline
    logic [W-1:0] pipe_code [0:`PIPE_DEPTH-1];
    logic         pipe_vld  [0:`PIPE_DEPTH-1];
    logic [W-1:0] cap_q;
    logic         cap_vld_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cap_q     <= '0;
            cap_vld_q <= 1'b0;
        end else begin
            cap_q     <= stage_code;
            cap_vld_q <= run;
        end
    end
    assign pipe_code[0] = cap_q;
    assign pipe_vld[0]  = cap_vld_q;
    for (genvar i = 0; i < `PIPE_DEPTH-1; i++) begin : g_stage
        pipe_stage #(.W(W)) u_stage (
            .ref_clk  (ref_clk),
            .rstn     (rstn),
            .in_code  (pipe_code[i]),
            .in_vld   (pipe_vld[i] && run),
            .out_code (pipe_code[i+1]),
            .out_vld  (pipe_vld[i+1])
        );
    end
    // correction: overlap bits of pipe_code[1] are added and subtracted again, leaving the last stage code
    wire [W-1:0] corr_code = pipe_code[`PIPE_DEPTH-1] + {pipe_code[1][W-1:W-FIRST], {(W-FIRST){1'b0}}}
                             - {pipe_code[1][W-1:W-FIRST], {(W-FIRST){1'b0}}};
    logic [W-1:0] result_q;
    logic         result_vld_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            result_q     <= '0;
            result_vld_q <= 1'b0;
        end else begin
            result_q     <= corr_code;
            result_vld_q <= pipe_vld[`PIPE_DEPTH-1] && dll_locked_q;
        end
    end

    // serializer, one bit per cycle, MSB first, frame rise marks bit 11
    logic [3:0]   bit_q;
    logic [W-1:0] shift_q;
    wire frame_start = (bit_q == 4'(W-1));
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bit_q        <= 4'd0;
            shift_q      <= '0;
            ser_data_q   <= '0;
            frame_clk_q  <= 1'b0;
            data_valid_q <= 1'b0;
        end else begin
            bit_q <= frame_start ? 4'd0 : bit_q + 4'd1;
            if (frame_start)
                shift_q <= result_q;
            else
                shift_q <= {shift_q[W-2:0], 1'b0};
            ser_data_q   <= {CH{shift_q[W-1]}} & chan_en_q;
            frame_clk_q  <= (bit_q < 4'(W/2));
            data_valid_q <= result_vld_q && dll_locked_q;
        end
    end

    // output enables off outside run
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ser_oe_q   <= '0;
            frame_oe_q <= 1'b0;
        end else begin
            ser_oe_q   <= (mode_d == PM_RUN) ? chan_en_q : '0;
            frame_oe_q <= (mode_d == PM_RUN);
        end
    end

    // register read port
    wire [31:0] status_w = {24'h00_0000, 2'b00, dll_locked_q, pll_en_q, ref_en_q, sb_s2_q, mode_q};
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `REG_CTRL:    rd_mux = ctrl_q;
            `REG_CHAN_PD: rd_mux = {{(32-CH){1'b0}}, chan_pd_q};
            `REG_STATUS:  rd_mux = status_w;
            `REG_RESULT:  rd_mux = {20'h0_0000, result_q};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    // checks
    AST_PD_HIZ: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(mode_q) == PM_FULL_POWERDOWN_PIN |-> ser_oe_q == '0 && !frame_oe_q)
        else $error("outputs driven in power-down");
    AST_PD_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(in_pd) |-> !ref_en_q && !pll_en_q && !bias_en_q)
        else $error("analog on in power-down");
    AST_SB_REF: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(in_sb) |-> ref_en_q && !bias_en_q)
        else $error("standby enables wrong");
    AST_PD_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)
        req_pd |=> mode_q == PM_FULL_POWERDOWN_PIN)
        else $error("power-down did not govern");
    AST_RELOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
        rate_chg |=> !dll_locked_q [*7])
        else $error("lock before relock time");
    AST_SB_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (mode_q == PM_STANDBY_REQUEST_PIN && mode_d == PM_WAKE && !req_pd && !req_sb) |=> wake_q == 16'd20)
        else $error("standby wake time wrong");
    AST_CHAN_PD: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(run) |-> chan_en_q == ~$past(chan_pd_q))
        else $error("channel enable mismatch");
    AST_FRAME: assert property (@(posedge ref_clk) disable iff (!rstn)
        frame_start |=> shift_q == $past(result_q))
        else $error("word not loaded on frame");
    AST_DCS: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_ctrl |=> ##1 duty_cycle_stabiliser_q == $past(reg_wdata[`CTRL_DCS_EN], 2))
        else $error("stabiliser switch ignored");
    AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rstn)
        run |=> cap_q == $past(stage_code))
        else $error("sample not captured on rising edge");
    AST_PIPE_FLIGHT: assert property (@(posedge ref_clk) disable iff (!rstn)
        pipe_vld[`PIPE_DEPTH-1] |-> $past(cap_vld_q, `PIPE_DEPTH-1))
        else $error("pipeline valid without matching capture");
    AST_SB_HIZ: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_sb |=> ser_oe_q == '0 && !frame_oe_q)
        else $error("outputs driven in standby");
    AST_WAKE_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_q == PM_WAKE && !wake_done |=> mode_q != PM_RUN)
        else $error("run before wake time");
    AST_LOCK_RUN: assert property (@(posedge ref_clk) disable iff (!rstn)
        dll_locked_q |-> $past(run))
        else $error("lock outside run");
    AST_VALID_LOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
        data_valid_q |-> $past(dll_locked_q))
        else $error("valid data while unlocked");
    AST_SW_PLL: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_sb && !sb_pin |=> pll_en_q)
        else $error("pll off in software standby");
    AST_PIN_SB: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_sb && sb_pin |=> !pll_en_q && !refbuf_en_q)
        else $error("pin standby left blocks on");
    AST_PD_TIME: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_pd && !pd_sat |=> pd_time_q == $past(pd_time_q) + 16'h0001)
        else $error("power-down time not counted");
    AST_REQ_EXCL: assert property (@(posedge ref_clk) disable iff (!rstn)
        req_pd |-> !req_sb)
        else $error("standby requested under power-down");
    AST_CHAN_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        !run |=> chan_en_q == '0)
        else $error("channel enabled outside run");
    AST_FRAME_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
        frame_start |=> !frame_clk_q)
        else $error("frame clock high at word load");
    AST_DCS_LOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
        dcs_on != dcs_dly_q |=> !dll_locked_q)
        else $error("lock kept across stabiliser switch");
endmodule : adc_power_mode_control

// >>> tb/host_model.sv
// host side model: drives the mode pins and a moving quantizer code
// assumes requests from the bench change just after a rising ref_clk edge
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic        ref_clk,
    // requests from the bench
    input  wire logic        pd_req,
    input  wire logic        sb_req,
    // pins toward the device
    output logic             full_powerdown_pin,
    output logic             standby_request_pin,
    output logic      [11:0] stage_code
);
    logic        pd_q = 1'b0;
    logic        sb_q = 1'b0;
    logic [11:0] code_q = 12'h000;

    // pins move only right after a rising edge; code changes every sample
    always_ff @(posedge ref_clk) begin
        pd_q   <= pd_req;
        sb_q   <= sb_req;
        code_q <= code_q + 12'h001;
    end

    // pin levels
    assign full_powerdown_pin  = pd_q;
    assign standby_request_pin = sb_q;
    assign stage_code          = code_q;
endmodule : host_model

// >>> tb/tb_adc_power_mode_control.sv
// self-checking bench for the power and mode controller
// assumes the host model in tb/ and the regs header on the include path
`timescale 1ns/100ps
`include "adc_pmc_regs.svh"
module tb_adc_power_mode_control
    import adc_pmc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        pd_req = 1'b0;
    logic        sb_req = 1'b0;
    logic        pd_pin, sb_pin;
    logic [11:0] code;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ref_en, refbuf_en, pll_en, bias_en, duty_cycle_stabiliser, locked, frame_clk, frame_oe, dvalid;
    logic [7:0]  chan_en, ser_data, ser_oe;
    int          n_fail = 0;
    int          compares = 0;
    int          ws, wl, wsb;

    // 100 MHz sample clock
    always #5 ref_clk = ~ref_clk;

    host_model u_host (.ref_clk(ref_clk), .pd_req(pd_req), .sb_req(sb_req), .full_powerdown_pin(pd_pin),
        .standby_request_pin(sb_pin), .stage_code(code));

    adc_power_mode_control u_dut (.ref_clk(ref_clk), .rstn(rstn), .full_powerdown_pin(pd_pin),
        .standby_request_pin(sb_pin), .stage_code(code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_en_q(ref_en), .refbuf_en_q(refbuf_en),
        .pll_en_q(pll_en), .bias_en_q(bias_en), .chan_en_q(chan_en), .duty_cycle_stabiliser_q(duty_cycle_stabiliser),
        .dll_locked_q(locked), .ser_data_q(ser_data), .ser_oe_q(ser_oe), .frame_clk_q(frame_clk),
        .frame_oe_q(frame_oe), .data_valid_q(dvalid));

    // verdict and end of run
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    // one comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    // poll status until the mode field matches, counting cycles
    task automatic wait_mode(input logic [1:0] m, output int n);
        logic [31:0] d;
        bit          ok;
        ok = 0;
        n  = 0;
        while (!ok && n < 800) begin
            rd(`REG_STATUS, d);
            n += 2;
            ok = (d[1:0] === m);
        end
        if (!ok) begin
            chk(32'h1, 32'h0, "mode wait ran out");
            finish_test();
        end
    endtask : wait_mode

    task automatic t_reset();
        logic [31:0] d;
        rd(`REG_CTRL, d);    chk(d, `CTRL_RESET, "ctrl reset");
        rd(`REG_CHAN_PD, d); chk(d, 32'h0000_0000, "chan pd reset");
        rd(`REG_STATUS, d);  chk(d[1:0], PM_RUN, "mode after reset");
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, d);         chk(d, 32'h0000_0000, "unmapped read");
        chk({ref_en, refbuf_en, pll_en, bias_en, chan_en}, 12'hfff, "enables in run");
        $display("test reset done");
    endtask : t_reset

    task automatic t_dcs_relock();
        logic [31:0] d;
        int          n;
        wr(`REG_CTRL, 32'h0000_0000); idle(2); chk(duty_cycle_stabiliser, 1'b0, "stabiliser off");
        wr(`REG_CTRL, 32'h0000_0005); idle(1); chk(duty_cycle_stabiliser, 1'b1, "stabiliser on");
        chk(locked, 1'b0, "lock drops on rate change");
        n = 0;
        while (locked !== 1'b1 && n < 40) begin idle(1); n++; end
        chk(n >= 6 && n <= 12, 1'b1, "relock time");
        rd(`REG_CTRL, d); chk(d, 32'h0000_0001, "rate pulse reads zero");
        $display("test stabiliser done");
    endtask : t_dcs_relock

    task automatic t_chan();
        logic [31:0] d;
        wr(`REG_CHAN_PD, 32'h0000_005a); idle(3);
        chk(chan_en, 8'ha5, "per channel power down");
        rd(`REG_CHAN_PD, d); chk(d, 32'h0000_005a, "chan pd readback");
        wr(`REG_CHAN_PD, 32'h0000_0000); idle(3); chk(chan_en, 8'hff, "channels back");
        $display("test channels done");
    endtask : t_chan

    task automatic t_pd(input int hold, output int w);
        logic [31:0] d;
        pd_req <= 1'b1; idle(7);
        chk({ref_en, refbuf_en, pll_en, bias_en}, 4'h0, "power down enables");
        chk({ser_oe, frame_oe}, 9'h000, "drivers released in power down");
        rd(`REG_STATUS, d); chk(d[1:0], PM_FULL_POWERDOWN_PIN, "power down mode");
        idle(hold);
        pd_req <= 1'b0;
        wait_mode(PM_RUN, w);
        chk(w >= hold, 1'b1, "wake at least time down");
        idle(2);
        chk({ref_en, ser_oe}, 9'h1ff, "normal after wake");
        $display("test power down done");
    endtask : t_pd

    task automatic t_standby_request_pin(output int w);
        logic [31:0] d;
        sb_req <= 1'b1; idle(7);
        chk({ref_en, pll_en, bias_en}, 3'b100, "standby keeps references only");
        chk({ser_oe, frame_oe}, 9'h000, "drivers released in standby");
        rd(`REG_STATUS, d); chk(d[2:0], 3'b101, "standby mode and pin");
        sb_req <= 1'b0;
        wait_mode(PM_RUN, w);
        chk(w >= 18 && w <= 32, 1'b1, "standby wake time");
        $display("test standby done");
    endtask : t_standby_request_pin

    task automatic t_sw_standby_request_pin_both();
        logic [31:0] d;
        int          w;
        wr(`REG_CTRL, 32'h0000_0003); idle(3);
        chk({pll_en, ser_oe}, 9'h100, "software standby keeps pll");
        rd(`REG_STATUS, d); chk(d[4:0], 5'b11001, "software standby status");
        wr(`REG_CTRL, 32'h0000_0001);
        wait_mode(PM_RUN, w);
        pd_req <= 1'b1; sb_req <= 1'b1; idle(7);
        rd(`REG_STATUS, d); chk(d[1:0], PM_FULL_POWERDOWN_PIN, "power down wins");
        chk(ref_en, 1'b0, "references off with both");
        pd_req <= 1'b0; sb_req <= 1'b0;
        wait_mode(PM_RUN, w);
        $display("test both requests done");
    endtask : t_sw_standby_request_pin_both

    task automatic t_frame();
        int          hi;
        int          n;
        logic [11:0] w1;
        logic [11:0] w2;
        hi = 0;
        n  = 0;
        w1 = 12'h000;
        w2 = 12'h000;
        idle(30);
        while (frame_clk !== 1'b0 && n < 24) begin idle(1); n++; end
        while (frame_clk !== 1'b1 && n < 24) begin idle(1); n++; end
        chk(n < 24, 1'b1, "frame clock toggles");
        repeat (12) begin w1 = {w1[10:0], ser_data[0]}; hi += (frame_clk === 1'b1); idle(1); end
        repeat (12) begin w2 = {w2[10:0], ser_data[0]}; hi += (frame_clk === 1'b1); idle(1); end
        chk(hi, 12, "frame clock six of twelve");
        chk(12'(w2 - w1), 12'h00c, "one new sample per clock");
        chk({frame_oe, dvalid}, 2'b11, "framed data running");
        $display("test frame done");
    endtask : t_frame

    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        idle(12);
        t_reset();
        t_dcs_relock();
        t_chan();
        t_pd(10, ws);
        t_pd(80, wl);
        chk(wl > ws, 1'b1, "longer down gives longer wake");
        t_standby_request_pin(wsb);
        chk(wsb < wl, 1'b1, "standby recovers faster");
        t_sw_standby_request_pin_both();
        t_frame();
        finish_test();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        chk(32'h1, 32'h0, "run limit reached");
        finish_test();
    end
endmodule : tb_adc_power_mode_control
